// >>> design/sio_shift_unit.sv
// Synchronous 8-bit serial shift unit with Wishbone register access.
// Assumes a single 50 MHz clock; clock pin and data input are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module sio_shift_unit import sio_pkg::*; #(
	parameter int LOW_HALF = LOW_SPEED_HALF_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire logic i_sck,
	output logic o_sck,
	output logic o_sck_oe,
	input wire logic i_si,
	output logic o_so,
	output logic o_serial_irq
);
	sio_clk_if clk_bus ();

	// Register state
	logic [2:0] clk_code_r, clk_code_nxt;
	logic dir_r, dir_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic start_r, start_nxt;
	logic divsel_r, divsel_nxt;
	logic slow_r, slow_nxt;
	logic tx_underrun_flag_r, tx_underrun_flag_nxt;
	logic rx_overrun_flag_r, rx_overrun_flag_nxt;
	logic txempty_r, txempty_nxt;
	logic rxfull_r, rxfull_nxt;
	logic [7:0] txbuf_r, txbuf_nxt;
	logic [7:0] rxbuf_r, rxbuf_nxt;
	// Link state
	link_state_t st_r, st_nxt;
	logic [3:0] bit_cnt_r, bit_cnt_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic so_r, so_nxt;
	logic irq_r, irq_nxt;
	logic si_s1_r, si_s2_r;
	// Bus state
	logic ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;

	logic req, wr, rd;
	logic tx_on, rx_on, ready, boundary;

	// Bus decode; the access takes effect at the edge where ack rises
	assign req = i_wb_cyc && i_wb_stb && !ack_r;
	assign wr = req && i_wb_we;
	assign rd = req && !i_wb_we;
	assign tx_on = (mode_r != MODE_RX);
	assign rx_on = (mode_r != MODE_TX);
	assign boundary = (bit_cnt_r == 4'h0);
	// Internal clock may start a byte only with data to send when transmitting and room to receive when receiving
	assign ready = (!tx_on || !txempty_r) && (!rx_on || !rxfull_r);

	assign clk_bus.clk_code = clk_code_r;
	assign clk_bus.div_sel = divsel_r;
	assign clk_bus.slow_mode = slow_r;
	assign clk_bus.run = (st_r == ST_SHIFT) || (start_r && ready);

	sio_clk_gen #(
		.LOW_HALF(LOW_HALF)
	) u_clk_gen (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_sck(i_sck),
		.o_sck(o_sck),
		.o_sck_oe(o_sck_oe),
		.clk_bus(clk_bus)
	);

	// Read data mux
	function automatic logic [31:0] read_word(input logic [7:0] adr, input logic [31:0] ctl,
		input logic [31:0] sts, input logic [7:0] rxb);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (adr)
			OFS_CONTROL: v = ctl;
			OFS_STATUS: v = sts;
			OFS_RX_BUFFER: v = {24'h00_0000, rxb};
			default: v = 32'h0000_0000; // Transmit buffer and holes read zero
		endcase
		return v;
	endfunction : read_word

	// Bus and register next state
	always_comb begin
		logic [31:0] ctl;
		logic [31:0] sts;
		ctl = 32'h0000_0000;
		sts = 32'h0000_0000;
		ctl[CTL_CLK_LSB +: 3] = clk_code_r;
		ctl[CTL_DIR] = dir_r;
		ctl[CTL_MODE_LSB +: 2] = mode_r;
		ctl[CTL_START] = start_r;
		ctl[CTL_DIVSEL] = divsel_r;
		ctl[CTL_SLOW] = slow_r;
		sts[ST_TX_UNDERRUN_FLAG] = tx_underrun_flag_r;
		sts[ST_RX_OVERRUN_FLAG] = rx_overrun_flag_r;
		sts[ST_TXEMPTY] = txempty_r;
		sts[ST_RXFULL] = rxfull_r;
		sts[ST_ACTIVE] = (st_r != ST_IDLE);
		sts[ST_SHIFTING] = !boundary;
		ack_nxt = req;
		rdat_nxt = rd ? read_word(i_wb_adr, ctl, sts, rxbuf_r) : 32'h0000_0000;

		clk_code_nxt = clk_code_r;
		dir_nxt = dir_r;
		mode_nxt = mode_r;
		start_nxt = start_r;
		divsel_nxt = divsel_r;
		slow_nxt = slow_r;
		tx_underrun_flag_nxt = tx_underrun_flag_r;
		rx_overrun_flag_nxt = rx_overrun_flag_r;
		txempty_nxt = txempty_r;
		rxfull_nxt = rxfull_r;
		txbuf_nxt = txbuf_r;
		rxbuf_nxt = rxbuf_r;
		st_nxt = st_r;
		bit_cnt_nxt = bit_cnt_r;
		shift_nxt = shift_r;
		so_nxt = so_r;
		irq_nxt = 1'b0;

		// Software side effects other than the forced stop come first so that hardware events win
		if (wr && i_wb_adr == OFS_CONTROL && i_wb_sel[0]) begin
			clk_code_nxt = i_wb_dat[CTL_CLK_LSB +: 3];
			dir_nxt = i_wb_dat[CTL_DIR];
			mode_nxt = i_wb_dat[CTL_MODE_LSB +: 2];
			start_nxt = i_wb_dat[CTL_START];
		end
		if (wr && i_wb_adr == OFS_CONTROL && i_wb_sel[1]) begin
			divsel_nxt = i_wb_dat[CTL_DIVSEL];
			slow_nxt = i_wb_dat[CTL_SLOW];
		end
		if (wr && i_wb_adr == OFS_STATUS && i_wb_sel[0]) begin
			if (!i_wb_dat[ST_TX_UNDERRUN_FLAG])
				tx_underrun_flag_nxt = 1'b0;
			if (!i_wb_dat[ST_RX_OVERRUN_FLAG])
				rx_overrun_flag_nxt = 1'b0;
		end
		if (wr && i_wb_adr == OFS_TX_BUFFER && i_wb_sel[0] && txempty_r) begin
			txbuf_nxt = i_wb_dat[7:0];
			txempty_nxt = 1'b0;
		end
		if (rd && i_wb_adr == OFS_RX_BUFFER)
			rxfull_nxt = 1'b0;

		// Shift engine
		case (st_r)
			ST_IDLE, ST_HOLD: begin
				if (!start_r) begin
					st_nxt = ST_IDLE;
				end else if (clk_bus.fall && (clk_bus.external || ready)) begin
					st_nxt = ST_SHIFT;
					bit_cnt_nxt = 4'h1;
					shift_nxt = txbuf_r;
					if (tx_on && txempty_r) begin
						tx_underrun_flag_nxt = 1'b1;
						irq_nxt = 1'b1;
						so_nxt = 1'b1;
					end else if (tx_on) begin
						txempty_nxt = 1'b1; // Buffer handed to shifter
						so_nxt = dir_r ? txbuf_r[0] : txbuf_r[7];
					end
				end
			end
			ST_SHIFT: begin
				if (clk_bus.rise) begin
					shift_nxt = dir_r ? {si_s2_r, shift_r[7:1]} : {shift_r[6:0], si_s2_r};
					if (bit_cnt_r == BITS_PER_BYTE) begin
						bit_cnt_nxt = 4'h0;
						st_nxt = start_r ? ST_HOLD : ST_IDLE;
						irq_nxt = 1'b1;
						if (rx_on && rxfull_r && clk_bus.external) begin
							rx_overrun_flag_nxt = 1'b1;
						end else if (rx_on) begin
							rxbuf_nxt = dir_r ? {si_s2_r, shift_r[7:1]} : {shift_r[6:0], si_s2_r};
							rxfull_nxt = 1'b1;
						end
					end
				end else if (clk_bus.fall) begin
					bit_cnt_nxt = bit_cnt_r + 4'h1;
					if (tx_on && !tx_underrun_flag_r)
						so_nxt = dir_r ? shift_r[0] : shift_r[7];
				end
			end
			default: begin
				st_nxt = ST_IDLE;
				bit_cnt_nxt = 4'h0;
			end
		endcase
		if (st_nxt == ST_IDLE || !tx_on)
			so_nxt = 1'b1;

		// Forced stop overrides everything except the shift register and the control fields other than start
		if (wr && i_wb_adr == OFS_CONTROL && i_wb_sel[0] && i_wb_dat[CTL_STOP]) begin
			start_nxt = 1'b0;
			tx_underrun_flag_nxt = 1'b0;
			rx_overrun_flag_nxt = 1'b0;
			txempty_nxt = 1'b1;
			rxfull_nxt = 1'b0;
			txbuf_nxt = TX_BUF_RESET;
			rxbuf_nxt = RX_BUF_RESET;
			st_nxt = ST_IDLE;
			bit_cnt_nxt = 4'h0;
			so_nxt = 1'b1;
			irq_nxt = 1'b0;
		end
	end

	// Register all state
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			clk_code_r <= CLK_SLOWEST;
			dir_r <= 1'b0;
			mode_r <= MODE_TX;
			start_r <= 1'b0;
			divsel_r <= 1'b0;
			slow_r <= 1'b0;
			tx_underrun_flag_r <= 1'b0;
			rx_overrun_flag_r <= 1'b0;
			txempty_r <= 1'b1;
			rxfull_r <= 1'b0;
			txbuf_r <= TX_BUF_RESET;
			rxbuf_r <= RX_BUF_RESET;
			st_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			so_r <= 1'b1;
			irq_r <= 1'b0;
			si_s1_r <= 1'b1;
			si_s2_r <= 1'b1;
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
		end else begin
			clk_code_r <= clk_code_nxt;
			dir_r <= dir_nxt;
			mode_r <= mode_nxt;
			start_r <= start_nxt;
			divsel_r <= divsel_nxt;
			slow_r <= slow_nxt;
			tx_underrun_flag_r <= tx_underrun_flag_nxt;
			rx_overrun_flag_r <= rx_overrun_flag_nxt;
			txempty_r <= txempty_nxt;
			rxfull_r <= rxfull_nxt;
			txbuf_r <= txbuf_nxt;
			rxbuf_r <= rxbuf_nxt;
			st_r <= st_nxt;
			bit_cnt_r <= bit_cnt_nxt;
			shift_r <= shift_nxt;
			so_r <= so_nxt;
			irq_r <= irq_nxt;
			si_s1_r <= i_si;
			si_s2_r <= si_s1_r;
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rdat_r;
	assign o_so = so_r;
	assign o_serial_irq = irq_r;
endmodule : sio_shift_unit
`default_nettype wire

// >>> design/sio_pkg.sv
// Constants, register map and types of the synchronous serial shift unit.
// Assumes a 50 MHz main clock and a 32-bit classic Wishbone slave port.
package sio_pkg;
	localparam int CLK_HZ = 50_000_000;
	// Register byte offsets
	localparam logic [7:0] OFS_CONTROL = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_TX_BUFFER = 8'h28;
	localparam logic [7:0] OFS_RX_BUFFER = 8'h2C;
	// Control field positions
	localparam int CTL_CLK_LSB = 0;
	localparam int CTL_DIR = 3;
	localparam int CTL_MODE_LSB = 4;
	localparam int CTL_START = 6;
	localparam int CTL_STOP = 7;
	localparam int CTL_DIVSEL = 8;
	localparam int CTL_SLOW = 9;
	// Status field positions
	localparam int ST_TX_UNDERRUN_FLAG = 0;
	localparam int ST_RX_OVERRUN_FLAG = 1;
	localparam int ST_TXEMPTY = 2;
	localparam int ST_RXFULL = 3;
	localparam int ST_ACTIVE = 4;
	localparam int ST_SHIFTING = 5;
	// Codes and reset values
	localparam logic [2:0] CLK_EXTERNAL = 3'h7;
	localparam logic [2:0] CLK_SLOWEST = 3'h0;
	localparam logic [1:0] MODE_TX = 2'h0;
	localparam logic [1:0] MODE_RX = 2'h1;
	localparam logic [7:0] RX_BUF_RESET = 8'h00;
	localparam logic [7:0] TX_BUF_RESET = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	// Low-speed clock: 32768 Hz, divided by 2^4, half period in main cycles
	localparam int LOW_SPEED_HZ = 32_768;
	localparam int LOW_SPEED_HALF_CYCLES = CLK_HZ / ((LOW_SPEED_HZ / 16) * 2);
	localparam int HALF_CNT_W = 16;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SHIFT = 2'b01,
		ST_HOLD = 2'b11
	} link_state_t;
endpackage : sio_pkg

// >>> design/sio_clk_if.sv
// Signals between the shift core and its serial clock unit.
// Assumes both ends run on the same main clock.
`timescale 1ns/1ps
`default_nettype none
interface sio_clk_if;
	logic [2:0] clk_code;
	logic div_sel;
	logic slow_mode;
	logic run;
	logic fall;
	logic rise;
	logic external;
	modport core (output clk_code, output div_sel, output slow_mode, output run, input fall, input rise,
		input external);
	modport gen (input clk_code, input div_sel, input slow_mode, input run, output fall, output rise,
		output external);
endinterface : sio_clk_if
`default_nettype wire

// >>> design/sio_clk_gen.sv
// Serial clock unit: internal rate divider or synchronised external clock.
// Assumes the pin input is asynchronous to the main clock.
`timescale 1ns/1ps
`default_nettype none
module sio_clk_gen import sio_pkg::*; #(
	parameter int LOW_HALF = LOW_SPEED_HALF_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_sck,
	output logic o_sck,
	output logic o_sck_oe,
	sio_clk_if.gen clk_bus
);
	logic [HALF_CNT_W-1:0] cnt_r, cnt_nxt;
	logic sck_r, sck_nxt;
	logic sync1_r, sync2_r, sync3_r;
	logic [HALF_CNT_W-1:0] half;
	logic ext;

	// Half period in main cycles for a clock code
	function automatic logic [HALF_CNT_W-1:0] half_cycles(input logic [2:0] code, input logic dsel,
		input logic slow);
		logic [HALF_CNT_W-1:0] h;
		h = HALF_CNT_W'(2048);
		if (slow || (dsel && code == CLK_SLOWEST))
			h = HALF_CNT_W'(LOW_HALF);
		else if (code != CLK_SLOWEST)
			h = HALF_CNT_W'(16'h0100 >> code);
		return h;
	endfunction : half_cycles

	assign ext = (clk_bus.clk_code == CLK_EXTERNAL);
	assign half = half_cycles(clk_bus.clk_code, clk_bus.div_sel, clk_bus.slow_mode);

	// Internal clock: falls only while run is asked, always returns high
	always_comb begin
		cnt_nxt = cnt_r;
		sck_nxt = sck_r;
		if (ext) begin
			cnt_nxt = '0;
			sck_nxt = 1'b1;
		end else if (!sck_r || clk_bus.run) begin
			if (cnt_r >= half - 1'b1) begin
				cnt_nxt = '0;
				sck_nxt = !sck_r;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end else begin
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt_r <= '0;
			sck_r <= 1'b1;
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			sync3_r <= 1'b1;
		end else begin
			cnt_r <= cnt_nxt;
			sck_r <= sck_nxt;
			sync1_r <= i_sck;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// Edge pulses toward the core
	always_comb begin
		clk_bus.external = ext;
		if (ext) begin
			clk_bus.fall = sync3_r && !sync2_r;
			clk_bus.rise = !sync3_r && sync2_r;
		end else begin
			clk_bus.fall = sck_r && !sck_nxt;
			clk_bus.rise = !sck_r && sck_nxt;
		end
	end

	assign o_sck = sck_r;
	assign o_sck_oe = !ext;
endmodule : sio_clk_gen
`default_nettype wire

// >>> dv/sio_shift_unit_properties.sv
// Port checks for the serial shift unit.
// Assumes binding into sio_shift_unit; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module sio_shift_unit_properties import sio_pkg::*; #(
	parameter int LOW_HALF = LOW_SPEED_HALF_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic [31:0] o_wb_dat,
	input wire logic o_wb_ack,
	input wire logic o_sck,
	input wire logic o_sck_oe,
	input wire logic o_so,
	input wire logic o_serial_irq
);
	localparam int LIM = LOW_HALF > 2048 ? LOW_HALF : 2048;
	logic [15:0] low_r;
	logic [15:0] low_nxt;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);
	// Cycles the driven clock pin has been low
	always_comb begin
		low_nxt = (o_sck || !o_sck_oe) ? 16'h0000 : low_r + 16'h0001;
	end
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			low_r <= 16'h0000;
		end else begin
			low_r <= low_nxt;
		end
	end
	a_ack_single: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack too long");
	a_ack_answers: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
	a_ack_needs_req: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack) else $error("stray ack");
	a_rdat_quiet: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000) else $error("data outside ack");
	a_so_on_fall: assert property (o_sck_oe && $fell(o_so) |-> $past(o_sck) && !o_sck)
		else $error("data moved off falling edge");
	a_irq_single: assert property (o_serial_irq |=> !o_serial_irq) else $error("irq too long");
	a_irq_clk_high: assert property (o_serial_irq && o_sck_oe |-> o_sck [*3])
		else $error("clock low near byte end");
	a_sck_low_bound: assert property (low_r <= LIM) else $error("clock stuck low");
	c_irq: cover property (o_serial_irq);
	c_fall: cover property ($fell(o_sck));
	c_read: cover property (o_wb_ack && o_wb_dat != 32'h0000_0000);
endmodule : sio_shift_unit_properties
bind sio_shift_unit sio_shift_unit_properties #(.LOW_HALF(LOW_HALF)) u_props (.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
	.o_sck(o_sck), .o_sck_oe(o_sck_oe), .o_so(o_so), .o_serial_irq(o_serial_irq));
`default_nettype wire

// >>> dv/sio_partner.sv
// Far-side serial peripheral: shifts a byte out and captures one.
// Assumes the clock line is resolved by the bench.
`timescale 1ns/1ps
`default_nettype none
module sio_partner (
	input wire logic i_line,
	input wire logic i_so,
	input wire logic i_lsb,
	input wire logic [7:0] i_tx,
	input wire logic i_run,
	output logic o_sck,
	output logic o_si,
	output logic [7:0] o_rx
);
	int n;
	initial begin
		o_sck = 1'b1;
		o_si = 1'b1;
		o_rx = 8'h00;
		n = 0;
	end
	// Own clock only while asked, each phase eight main cycles
	always begin
		wait (i_run);
		#160 o_sck = 1'b0;
		#160 o_sck = 1'b1;
	end
	// Next bit on the falling edge, same order both ways
	always @(negedge i_line) begin
		o_si = i_tx[i_lsb ? n : 7 - n];
		n = (n + 1) % 8;
	end
	// Capture on the rising edge
	always @(posedge i_line) begin
		o_rx = i_lsb ? {i_so, o_rx[7:1]} : {o_rx[6:0], i_so};
	end
endmodule : sio_partner
`default_nettype wire

// >>> dv/sync_serial_clock_shift_unit_bench.sv
// Self-checking bench for the serial shift unit.
// Assumes the partner model on the clock and data pins.
`timescale 1ns/1ps
`default_nettype none
module sync_serial_clock_shift_unit_bench import sio_pkg::*;;
	localparam int HALF = 8;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d;} row_t;
	logic clk, rst, cyc, stb, we, sck, oe, so, irq, xsck, si, lsb, run, ack;
	logic [7:0] adr, ptx, prx;
	logic [31:0] wd, rd, q;
	int mismatches, n_tests, k;
	wire line = oe ? sck : xsck;
	row_t rows[8] = '{'{1'b0, OFS_STATUS, 32'h0000_0004}, '{1'b0, OFS_RX_BUFFER, '0},
		'{1'b1, OFS_RX_BUFFER, 32'h0000_00FF}, '{1'b0, OFS_RX_BUFFER, '0}, '{1'b0, OFS_TX_BUFFER, '0},
		'{1'b1, OFS_STATUS, 32'h0000_0003}, '{1'b0, OFS_STATUS, 32'h0000_0004}, '{1'b0, 8'h30, '0}};
	sio_shift_unit #(.LOW_HALF(HALF)) u_sio_shift_unit (.i_clk_sys(clk), .i_sys_rst(rst), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd), .o_wb_dat(rd),
		.o_wb_ack(ack), .i_sck(line), .o_sck(sck), .o_sck_oe(oe), .i_si(si), .o_so(so), .o_serial_irq(irq));
	sio_partner u_sio_partner (.i_line(line), .i_so(so), .i_lsb(lsb), .i_tx(ptx), .i_run(run), .o_sck(xsck),
		.o_si(si), .o_rx(prx));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic give_verdict();
		if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	// Bounded wait: 0 ack, 1 irq, 2 clock low, 3 clock high
	task automatic await(input int s);
		int n;
		for (n = 0; n < 5000; n++) begin
			@(negedge clk);
			if (s == 0 ? ack === 1'b1 : s == 1 ? irq === 1'b1 : sck === s[0]) break;
		end
		if (n == 5000) begin
			mismatches++;
			give_verdict();
		end
	endtask : await
	// Classic single cycle, entered just after a rising or a falling clock edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		await(0);
		q = rd;
		@(posedge clk);
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : wb
	function automatic logic [31:0] ctl(logic [2:0] c, logic d, logic [1:0] m, logic s, logic x, logic [1:0] l);
		return {22'h00_0000, l, x, s, m, d, c};
	endfunction : ctl
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wd = '0;
		lsb = 1'b0;
		run = 1'b0;
		ptx = 8'h1C;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (rows[i]) begin
			wb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk(q, rows[i].d, "register");
		end
		chk(oe, 1'b1, "clock drive");
		// Internal clock: rates, order, refill refused, wait and release
		for (int i = 0; i < 3; i++) begin
			lsb <= i[0];
			wb(1'b1, OFS_TX_BUFFER, 32'h0000_0063);
			wb(1'b1, OFS_TX_BUFFER, 32'h0000_00FF);
			wb(1'b1, OFS_CONTROL, ctl(i ? 3'h0 : 3'h6, i[0], 2'h2, 1'b1, 1'b0, 2'(i)));
			await(2);
			for (k = 0; sck === 1'b0 && k < 9000; k++) @(negedge clk);
			chk(k, i ? HALF : 4, "half period");
			await(1);
			repeat (20) @(negedge clk);
			chk(sck, 1'b1, "stalled clock");
			chk(prx, 8'h63, "sent byte");
			wb(1'b1, OFS_TX_BUFFER, 32'h0000_0063);
			wb(1'b0, OFS_RX_BUFFER, '0);
			chk(q, 8'h1C, "received byte");
			for (k = 0; sck === 1'b1 && k < 9000; k++) @(negedge clk);
			chk(k <= (i ? 2 * HALF : 8), 1'b1, "restart delay");
			await(1);
			wb(1'b1, OFS_CONTROL, ctl(i ? 3'h0 : 3'h6, i[0], 2'h2, 1'b0, 1'b0, 2'(i)));
			wb(1'b0, OFS_RX_BUFFER, '0);
			chk(prx, 8'h63, "second byte");
		end
		// External clock: underrun, kept flags, overrun, forced stop
		wb(1'b1, OFS_CONTROL, ctl(CLK_EXTERNAL, 1'b0, MODE_TX, 1'b1, 1'b0, 2'h0));
		chk(oe, 1'b0, "clock drive");
		run <= 1'b1;
		q = 32'h0000_0001;
		// Data line must stay high for the whole underrun run
		for (k = 0; k < 200; k++) @(negedge clk) q[0] = q[0] & so;
		@(posedge clk);
		run <= 1'b0;
		chk(q[0], 1'b1, "line during underrun");
		repeat (40) @(posedge clk);
		wb(1'b1, OFS_CONTROL, ctl(CLK_EXTERNAL, 1'b0, MODE_TX, 1'b0, 1'b0, 2'h0));
		wb(1'b1, OFS_STATUS, 32'h0000_0003);
		wb(1'b0, OFS_STATUS, '0);
		chk(q[1:0], 2'h1, "underrun kept");
		wb(1'b1, OFS_STATUS, '0);
		wb(1'b0, OFS_STATUS, '0);
		chk(q[1:0], 2'h0, "underrun cleared");
		wb(1'b1, OFS_CONTROL, ctl(CLK_EXTERNAL, 1'b0, MODE_RX, 1'b1, 1'b0, 2'h0));
		run <= 1'b1;
		repeat (400) @(posedge clk);
		run <= 1'b0;
		repeat (40) @(posedge clk);
		wb(1'b0, OFS_STATUS, '0);
		chk(q[1:0], 2'h2, "overrun");
		wb(1'b1, OFS_CONTROL, ctl(CLK_EXTERNAL, 1'b0, MODE_RX, 1'b1, 1'b1, 2'h0));
		wb(1'b0, OFS_STATUS, '0);
		chk(q, 32'h0000_0004, "status after stop");
		wb(1'b0, OFS_RX_BUFFER, '0);
		chk(q, '0, "rx after stop");
		// Reset after the forced stop returns pins and control to idle
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({oe, sck, so, irq}, 4'hE, "pins after reset");
		wb(1'b0, OFS_CONTROL, '0);
		chk(q, '0, "control after reset");
		wb(1'b0, OFS_STATUS, '0);
		chk(q, 32'h0000_0004, "status after reset");
		give_verdict();
	end
endmodule : sync_serial_clock_shift_unit_bench
`default_nettype wire
